// >>> hw/lhi_host_if.sv
// Host interface of the LCD driver: pin front end, serial receiver and APB register file
//
// The placing of the registers and register access over APB were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lhi_regs.svh"

////////////////////////////////////////////////////////////////////////////////
module lhi_host_if
	import lhi_pkg::*;
(
	input  wire logic        SYS_CLK,          // System clock, 100 MHz
	input  wire logic        RST_B,            // Synchronous reset, active low
	input  wire logic        IFACE_SEL_A,      // Interface select pin A
	input  wire logic        IFACE_SEL_B,      // Interface select pin B
	input  wire logic        CHIP_SELECT_LOW_B,// Chip select, active low
	input  wire logic        CHIP_SELECT_HIGH, // Chip select, active high
	input  wire logic        DATA_COMMAND_FLAG,// High display data, low command/status
	input  wire logic        RD_STROBE,        // Read strobe low, or enable strobe
	input  wire logic        WR_STROBE,        // Write strobe low, or direction line
	input  wire logic [7:0]  DATA_IN,          // Data pins, input side
	output logic      [7:0]  DATA_OUT,         // Data pins, output side
	output logic             DATA_OE,          // High while driving data pins
	input  wire logic        PSEL,             // APB select
	input  wire logic        PENABLE,          // APB enable
	input  wire logic        PWRITE,           // APB direction
	input  wire logic [11:0] PADDR,            // APB byte address
	input  wire logic [31:0] PWDATA,           // APB write data
	output logic      [31:0] PRDATA,           // APB read data
	output logic             PREADY,           // APB ready
	output logic             PSLVERR           // APB error, unmapped address
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers: two flops on every pin

	localparam int NSYNC = 14;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;

	assign pin_raw = {IFACE_SEL_A, IFACE_SEL_B, CHIP_SELECT_LOW_B, CHIP_SELECT_HIGH,
		DATA_COMMAND_FLAG, RD_STROBE, WR_STROBE, DATA_IN[7], DATA_IN[6], DATA_IN[4:0]};

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			sync1_r <= '0;
			sync2_r <= '0;
		end else begin
			sync1_r <= pin_raw;
			sync2_r <= sync1_r;
		end
	end

	logic       sel_a_s;
	logic       sel_b_s;
	logic       csl_s;
	logic       csh_s;
	logic       flag_s;
	logic       rd_s;
	logic       wr_s;
	logic       d7_s;
	logic       d6_s;
	logic [4:0] dlow_s;
	logic [7:0] din_s;

	assign {sel_a_s, sel_b_s, csl_s, csh_s, flag_s, rd_s, wr_s, d7_s, d6_s, dlow_s} = sync2_r;

	////////////////////////////////////////////////////////////////////////////////
	// Bit 5 of the data pins, synchronised with the rest

	logic d5_m_r;
	logic d5_s_r;

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			d5_m_r <= 1'b0;
			d5_s_r <= 1'b0;
		end else begin
			d5_m_r <= DATA_IN[5];
			d5_s_r <= d5_m_r;
		end
	end

	assign din_s = {d7_s, d6_s, d5_s_r, dlow_s};

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode and chip select

	function automatic lhi_mode_type mode_of(input logic a, input logic b);
		mode_of = lhi_mode_type'({b ? a : a, b});
		case ({a, b})
			2'b01:   mode_of = LHI_MODE_SEP;
			2'b11:   mode_of = LHI_MODE_ENA;
			2'b10:   mode_of = LHI_MODE_SER;
			default: mode_of = LHI_MODE_RESET;
		endcase
	endfunction

	lhi_mode_type mode;
	logic         selected;

	assign mode     = mode_of(sel_a_s, sel_b_s);
	assign selected = !csl_s && csh_s;

	////////////////////////////////////////////////////////////////////////////////
	// Main state

	typedef struct packed {
		logic       sclk_prev;
		logic       access_prev;
		logic [7:0] cmd;
		logic [7:0] wdata;
		logic [7:0] status;
		logic [7:0] rdata;
		logic       dout_en;
		logic [7:0] dout;
		logic [7:0] cmd_cnt;
		logic [7:0] data_cnt;
		logic       cmd_new;
		logic       data_new;
		logic       cfg_lock;
	} lhi_state_type;

	lhi_state_type st_r;
	lhi_state_type st_nxt;

	logic       ser_en;
	logic       sclk_rise;
	logic       rx_vld;
	logic [7:0] rx_byte;
	logic       rx_is_data;

	assign ser_en    = (mode == LHI_MODE_SER) && selected;
	assign sclk_rise = d6_s && !st_r.sclk_prev;

	lhi_serial_rx lhi_serial_rx_i (
		.clk          (SYS_CLK),
		.rst_b        (RST_B),
		.enable       (ser_en),
		.sclk_rise    (sclk_rise),
		.sdata        (d7_s),
		.flag         (flag_s),
		.byte_vld     (rx_vld),
		.byte_out     (rx_byte),
		.byte_is_data (rx_is_data)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Parallel bus decode

	logic par_read;
	logic par_write;
	logic par_access;

	always_comb begin
		par_read  = 1'b0;
		par_write = 1'b0;
		if (selected) begin
			if (mode == LHI_MODE_SEP) begin
				par_read  = !rd_s;
				par_write = !wr_s && rd_s;
			end else if (mode == LHI_MODE_ENA) begin
				par_read  = rd_s && wr_s;
				par_write = rd_s && !wr_s;
			end
		end
	end

	assign par_access = par_write;

	logic apb_wr;

	assign apb_wr = PSEL && PENABLE && PWRITE;

	always_comb begin
		st_nxt = st_r;
		st_nxt.sclk_prev   = ser_en ? d6_s : 1'b0;
		st_nxt.access_prev = par_access;
		st_nxt.cmd_new     = 1'b0;
		st_nxt.data_new    = 1'b0;
		// Write acts once, on the end of the write strobe
		if (st_r.access_prev && !par_access) begin
			if (flag_s) begin
				st_nxt.wdata    = din_s;
				st_nxt.data_new = 1'b1;
			end else begin
				st_nxt.cmd     = din_s;
				st_nxt.cmd_new = 1'b1;
			end
		end
		if (rx_vld) begin
			if (rx_is_data) begin
				st_nxt.wdata    = rx_byte;
				st_nxt.data_new = 1'b1;
			end else begin
				st_nxt.cmd     = rx_byte;
				st_nxt.cmd_new = 1'b1;
			end
		end
		if (st_nxt.cmd_new)
			st_nxt.cmd_cnt = st_r.cmd_cnt + 8'h01;
		if (st_nxt.data_new)
			st_nxt.data_cnt = st_r.data_cnt + 8'h01;
		// Read path only on parallel modes
		st_nxt.dout_en = par_read && (mode != LHI_MODE_SER);
		st_nxt.dout    = flag_s ? st_r.rdata : st_r.status;
		if (apb_wr && (PADDR == `LHI_STATUS_OFS))
			st_nxt.status = PWDATA[7:0];
		if (apb_wr && (PADDR == `LHI_RDATA_OFS))
			st_nxt.rdata = PWDATA[7:0];
		if (apb_wr && (PADDR == `LHI_CTRL_OFS))
			st_nxt.cfg_lock = PWDATA[0];
		// Interface held in reset: clear command and data bytes, new flags and pin drive
		if (mode == LHI_MODE_RESET) begin
			st_nxt.cmd      = 8'h00;
			st_nxt.wdata    = 8'h00;
			st_nxt.dout_en  = 1'b0;
			st_nxt.cmd_new  = 1'b0;
			st_nxt.data_new = 1'b0;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (!RST_B) begin
			st_r <= '0;
			st_r.status <= `LHI_STATUS_RST;
			st_r.rdata  <= `LHI_RDATA_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign DATA_OUT = st_r.dout;
	assign DATA_OE  = st_r.dout_en;

	////////////////////////////////////////////////////////////////////////////////
	// APB slave, zero wait states

	logic [31:0] rd_mux;
	logic        unmapped;

	always_comb begin
		rd_mux   = 32'h0000_0000;
		unmapped = 1'b0;
		if (PADDR == `LHI_CTRL_OFS)
			rd_mux = {21'h0, st_r.cmd_new, st_r.data_new, ser_en, selected, 4'h0, mode, st_r.cfg_lock};
		else if (PADDR == `LHI_STATUS_OFS)
			rd_mux = {24'h0, st_r.status};
		else if (PADDR == `LHI_CMD_OFS)
			rd_mux = {24'h0, st_r.cmd};
		else if (PADDR == `LHI_WDATA_OFS)
			rd_mux = {24'h0, st_r.wdata};
		else if (PADDR == `LHI_RDATA_OFS)
			rd_mux = {24'h0, st_r.rdata};
		else if (PADDR == `LHI_RSTATUS_OFS)
			rd_mux = {24'h0, st_r.status};
		else if (PADDR == `LHI_COUNT_OFS)
			rd_mux = {16'h0, st_r.data_cnt, st_r.cmd_cnt};
		else
			unmapped = 1'b1;
	end

	assign PREADY  = 1'b1;
	assign PRDATA  = (PSEL && PENABLE && !PWRITE) ? rd_mux : 32'h0000_0000;
	assign PSLVERR = PSEL && PENABLE && unmapped;

endmodule
`default_nettype wire

// >>> hw/lhi_regs.svh
// Constants for the host interface of the LCD driver: register offsets, fields, reset values
`ifndef LHI_REGS_SVH
`define LHI_REGS_SVH

`define LHI_CTRL_OFS      12'h000
`define LHI_STATUS_OFS    12'h004
`define LHI_CMD_OFS       12'h008
`define LHI_WDATA_OFS     12'h00C
`define LHI_RDATA_OFS     12'h010
`define LHI_RSTATUS_OFS   12'h014
`define LHI_COUNT_OFS     12'h018

`define LHI_STATUS_RST    8'h00
`define LHI_RDATA_RST     8'h00
`define LHI_SER_BITS      4'h8
`define LHI_SEL_SEP       2'h1
`define LHI_SEL_ENA       2'h3
`define LHI_SEL_SER       2'h2
`define LHI_SEL_RST       2'h0

`endif

// >>> hw/lhi_pkg.sv
// Types shared by the LCD host interface design files
package lhi_pkg;

	typedef enum logic [1:0] {
		LHI_MODE_RESET  = 2'h0,
		LHI_MODE_SEP    = 2'h1,
		LHI_MODE_SER    = 2'h2,
		LHI_MODE_ENA    = 2'h3
	} lhi_mode_type;

endpackage

// >>> hw/lhi_serial_rx.sv
// Serial receiver: byte shift register and modulo-eight bit counter
`timescale 1ns/1ps
`default_nettype none
module lhi_serial_rx
	import lhi_pkg::*;
(
	input  wire logic       clk,       // System clock
	input  wire logic       rst_b,     // Synchronous reset, active low
	input  wire logic       enable,    // Serial mode and chip selected
	input  wire logic       sclk_rise, // One-cycle pulse on serial clock rise
	input  wire logic       sdata,     // Synchronised serial data
	input  wire logic       flag,      // Synchronised data/command flag
	output logic            byte_vld,  // One-cycle pulse, byte complete
	output logic [7:0]      byte_out,  // Assembled byte
	output logic            byte_is_data // Flag sampled with the eighth bit
);

	typedef struct packed {
		logic [7:0] shift;
		logic [2:0] count;
		logic       vld;
		logic [7:0] out;
		logic       is_data;
	} lhi_rx_state_type;

	lhi_rx_state_type st_r;
	lhi_rx_state_type st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.vld = 1'b0;
		if (!enable) begin
			st_nxt.shift = 8'h00;
			st_nxt.count = 3'h0;
		end else if (sclk_rise) begin
			st_nxt.shift = {st_r.shift[6:0], sdata};
			st_nxt.count = st_r.count + 3'h1;
			if (st_r.count == 3'h7) begin
				st_nxt.out = {st_r.shift[6:0], sdata};
				st_nxt.is_data = flag;
				st_nxt.vld = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign byte_vld     = st_r.vld;
	assign byte_out     = st_r.out;
	assign byte_is_data = st_r.is_data;

endmodule
`default_nettype wire

// >>> bench/lhi_host_sva.sv
// Concurrent checks on the host interface ports
`timescale 1ns/1ps
`default_nettype none
module lhi_host_sva (
	input wire logic        SYS_CLK,           // Clock
	input wire logic        RST_B,             // Reset
	input wire logic        IFACE_SEL_A,       // Select A
	input wire logic        IFACE_SEL_B,       // Select B
	input wire logic        CHIP_SELECT_LOW_B, // Select low
	input wire logic        CHIP_SELECT_HIGH,  // Select high
	input wire logic        RD_STROBE,         // Read or enable
	input wire logic        WR_STROBE,         // Write or direction
	input wire logic        DATA_OE,           // Pin drive
	input wire logic        PSEL,              // APB
	input wire logic        PENABLE,           // APB
	input wire logic [11:0] PADDR,             // APB
	input wire logic [31:0] PRDATA,            // APB
	input wire logic        PREADY,            // APB
	input wire logic        PSLVERR            // APB
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RST_B);
	a_oe_reset: assert property (disable iff (1'b0) !RST_B |=> !DATA_OE) else $error("drive in reset");
	a_oe_sel: assert property (DATA_OE |-> !$past(CHIP_SELECT_LOW_B, 3) && $past(CHIP_SELECT_HIGH, 3))
		else $error("drive while deselected");
	a_oe_mode: assert property (DATA_OE |-> $past(IFACE_SEL_B, 3)) else $error("drive in serial");
	a_oe_sep: assert property (DATA_OE && !$past(IFACE_SEL_A, 3) |-> !$past(RD_STROBE, 3))
		else $error("drive without read strobe");
	a_oe_ena: assert property (DATA_OE && $past(IFACE_SEL_A, 3) |-> $past(RD_STROBE, 3) && $past(WR_STROBE, 3))
		else $error("drive without enable read");
	a_ready_high: assert property (PSEL && !PENABLE |=> PREADY) else $error("wait state");
	a_err_unmapped: assert property (PSEL && PENABLE && PADDR > 12'h018 |-> PSLVERR) else $error("no error");
	a_err_read: assert property (PSLVERR |-> PRDATA == 32'h0) else $error("error read data");
	a_rd_idle: assert property (!(PSEL && PENABLE) |-> PRDATA == 32'h0) else $error("idle read data");
	cover property (DATA_OE && $past(IFACE_SEL_A, 3));
	cover property (DATA_OE && !$past(IFACE_SEL_A, 3));
	cover property (PSLVERR);
endmodule
`default_nettype wire

// >>> bench/lhi_mpu_model.sv
// Host processor model on the parallel and serial pins
`timescale 1ns/1ps
`default_nettype none
module lhi_mpu_model (
	input  wire logic       clk,   // System clock
	input  wire logic [7:0] din,   // Resolved data pins
	input  wire logic       oe,    // Device drives pins
	output logic      [1:0] sel,   // Select pins A,B
	output logic            csl_b, // Chip select low
	output logic            csh,   // Chip select high
	output logic            flag,  // Data/command flag
	output logic            rd,    // Read strobe or enable
	output logic            wr,    // Write strobe or direction
	output logic      [7:0] dq     // Host drive, inverted when released
);
	initial begin
		sel = 2'h1;
		csl_b = 1'b1;
		csh = 1'b0;
		flag = 1'b0;
		rd = 1'b1;
		wr = 1'b1;
		dq = 8'h00;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic setm(input logic [1:0] m);
		@(posedge clk);
		sel <= m;
		rd <= !m[1];
		wr <= 1'b1;
		hold(6);
	endtask
	task automatic xfer(input logic w, input logic f, input logic s, input logic [7:0] d, output logic [8:0] q);
		@(posedge clk);
		csl_b <= 1'b0;
		csh <= s;
		flag <= f;
		dq <= w ? d : ~dq;
		if (sel[1]) wr <= !w;
		hold(4);
		rd <= sel[1] | w;
		wr <= !w;
		hold(6);
		q = {oe, din};
		rd <= !sel[1];
		if (!sel[1]) wr <= 1'b1;
		hold(4);
		csl_b <= 1'b1;
		csh <= 1'b0;
		dq <= ~dq;
		hold(4);
		wr <= 1'b1;
	endtask
	task automatic ser(input logic f, input logic [15:0] d, input int n);
		@(posedge clk);
		csl_b <= 1'b0;
		csh <= 1'b1;
		flag <= f;
		dq[6] <= 1'b0;
		hold(3);
		for (int i = 15; i > 15 - n; i--) begin
			dq[7] <= d[i];
			dq[5:0] <= ~dq[5:0];
			#62.5 dq[6] = 1'b1;
			#62.5 dq[6] = 1'b0;
		end
		hold(8);
		csl_b <= 1'b1;
		dq[7] <= ~dq[7];
		hold(4);
	endtask
endmodule
`default_nettype wire

// >>> bench/lhi_host_if_tb.sv
// Self-checking bench for the LCD host interface
`timescale 1ns/1ps
`default_nettype none
`include "lhi_regs.svh"
module lhi_host_if_tb
	import lhi_pkg::*;
;
	logic        clk, rst_b, psel, penable, pwrite, pready, pslverr, oe, csl_b, csh, flag, rd, wr, e;
	logic [1:0]  sel;
	logic [7:0]  dq, dout, din;
	logic [8:0]  q;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] cnt;
	int          n_fail, compares;
	logic [10:0] rows [6] = '{11'h2A5, 11'h33C, 11'h600, 11'h7FF, 11'h281, 11'h75A}; // Mode, flag, byte
	assign din = oe ? dout : dq;
	lhi_host_if lhi_host_if_i (.SYS_CLK(clk), .RST_B(rst_b), .IFACE_SEL_A(sel[1]), .IFACE_SEL_B(sel[0]),
		.CHIP_SELECT_LOW_B(csl_b), .CHIP_SELECT_HIGH(csh), .DATA_COMMAND_FLAG(flag), .RD_STROBE(rd),
		.WR_STROBE(wr), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
	lhi_mpu_model lhi_mpu_model_i (.clk(clk), .din(din), .oe(oe), .sel(sel), .csl_b(csl_b), .csh(csh),
		.flag(flag), .rd(rd), .wr(wr), .dq(dq));
	task end_sim;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		compares++;
		if (s !== x) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rv,
		output logic ev);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		rv = prdata;
		ev = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			end_sim();
		end
	endtask
	task automatic wcnt();
		for (int i = 0; i < 40; i++) begin
			apb(1'b0, `LHI_COUNT_OFS, 32'h0, r, e);
			if (r[15:0] === cnt) break;
		end
		chk("count", r, {16'h0, cnt});
		if (r[15:0] !== cnt) end_sim();
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		cnt = 16'h0;
		repeat (12) @(posedge clk);
		rst_b <= 1'b1;
		apb(1'b0, `LHI_STATUS_OFS, 32'h0, r, e);
		chk("status reset", r, {24'h0, `LHI_STATUS_RST});
		wcnt();
		apb(1'b1, 12'h100, 32'hFF, r, e);
		apb(1'b0, 12'h01C, 32'h0, r, e);
		chk("unmapped", {r[30:0], e}, 32'h1);
		foreach (rows[k]) begin
			lhi_mpu_model_i.setm(rows[k][10:9]);
			lhi_mpu_model_i.xfer(1'b1, rows[k][8], 1'b1, rows[k][7:0], q);
			cnt = cnt + (rows[k][8] ? 16'h0100 : 16'h0001);
			wcnt();
			apb(1'b0, rows[k][8] ? `LHI_WDATA_OFS : `LHI_CMD_OFS, 32'h0, r, e);
			chk("par write", r, {24'h0, rows[k][7:0]});
		end
		apb(1'b1, `LHI_STATUS_OFS, 32'h5E, r, e);
		apb(1'b1, `LHI_RDATA_OFS, 32'hC3, r, e);
		for (int j = 0; j < 4; j++) begin
			lhi_mpu_model_i.setm(j[1] ? LHI_MODE_ENA : LHI_MODE_SEP);
			lhi_mpu_model_i.xfer(1'b0, j[0], 1'b1, 8'h00, q);
			chk("par read", {23'h0, q}, {23'h0, 1'b1, j[0] ? 8'hC3 : 8'h5E});
		end
		lhi_mpu_model_i.xfer(1'b1, 1'b0, 1'b0, 8'h77, q);
		lhi_mpu_model_i.xfer(1'b0, 1'b0, 1'b0, 8'h00, q);
		chk("deselected drive", {31'h0, q[8]}, 32'h0);
		wcnt();
		lhi_mpu_model_i.setm(LHI_MODE_SER);
		lhi_mpu_model_i.ser(1'b0, 16'hC627, 16);
		cnt = cnt + 16'h0002;
		wcnt();
		apb(1'b0, `LHI_CMD_OFS, 32'h0, r, e);
		chk("serial cmd", r, 32'h27);
		chk("serial drive", {31'h0, oe}, 32'h0);
		lhi_mpu_model_i.ser(1'b1, 16'hFF00, 5);
		lhi_mpu_model_i.ser(1'b1, 16'h9300, 8);
		cnt = cnt + 16'h0100;
		wcnt();
		apb(1'b0, `LHI_WDATA_OFS, 32'h0, r, e);
		chk("serial data", r, 32'h93);
		lhi_mpu_model_i.setm(LHI_MODE_RESET);
		apb(1'b0, `LHI_CMD_OFS, 32'h0, r, e);
		chk("held cmd", r, 32'h0);
		// Reset in mid-run clears the counters and the status byte
		rst_b <= 1'b0;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		cnt = 16'h0;
		wcnt();
		apb(1'b0, `LHI_STATUS_OFS, 32'h0, r, e);
		chk("status mid reset", r, {24'h0, `LHI_STATUS_RST});
		end_sim();
	end
endmodule
bind lhi_host_if lhi_host_sva lhi_host_sva_i (.*);
`default_nettype wire
